/* File: rtl/rco_conv.sv */
// resistor-capacitor oscillation converter: two timers and registers
//
// Operation
// - two independent 16-bit count-up timers
// - converter works only with mode enable set
// - timer b counts oscillator, a counts reference
// - select 000 system clock, 001 divide four
// - run bit starts both timers together
// - selected overflow stops both, clears run
// - mode bit 0 picks overflow source
// - selected overflow sets interrupt request flag
// - low-byte write only fills buffer
// - high-byte write loads high and buffer
// - high-byte read latches low byte
// - low-byte read returns buffer only
// - timer registers blocked while run set
// - control bits 0-2 zero, bit 3 storage
// - mode bits 2-3 zero, 4-7 storage
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module rco_conv #(
    parameter int WIDTH = rco_pkg::TIMER_WIDTH
) (
    input  wire logic       clk,    // system clock, 100 MHz
    input  wire logic       reset,  // synchronous reset, active high
    input  wire logic       rc_osc, // external oscillator, synchronous
    input  wire logic [7:0] addr,   // register offset
    input  wire logic [7:0] wdata,  // write data
    input  wire logic       wr,     // write strobe
    input  wire logic       rd,     // read strobe
    output logic      [7:0] rdata_q, // read data, cycle after rd
    output logic            irq_q   // interrupt level
);
    logic [7:0]       ctrl_q;
    logic [7:0]       mode_q;
    logic             flag_q;
    logic             mask_q;
    logic             rc_q;
    logic             rc_prev_q;
    logic             run;
    logic             active;
    logic             tick_a;
    logic             tick_b;
    logic             wrap_a;
    logic             wrap_b;
    logic             sel_ovf;
    logic             flag_clr;
    logic [2:0]       sel;
    logic [WIDTH-1:0] cnt_a;
    logic [WIDTH-1:0] cnt_b;
    logic [7:0]       buf_a;
    logic [7:0]       buf_b;
    logic             wr_ah;
    logic             wr_al;
    logic             wr_bh;
    logic             wr_bl;
    logic             rd_ah;
    logic             rd_bh;
    logic [7:0]       rdata_d;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign run    = ctrl_q[rco_pkg::CTRL_RUN_BIT];
    assign sel    = ctrl_q[rco_pkg::CTRL_SEL_MSB:rco_pkg::CTRL_SEL_LSB];
    assign active = run && mode_q[rco_pkg::MODE_EN_BIT];

    // timer byte accesses are ignored while running
    assign wr_ah = wr && !run && hit(addr, rco_pkg::ADDR_TA_HIGH);
    assign wr_al = wr && !run && hit(addr, rco_pkg::ADDR_TA_LOW);
    assign wr_bh = wr && !run && hit(addr, rco_pkg::ADDR_TB_HIGH);
    assign wr_bl = wr && !run && hit(addr, rco_pkg::ADDR_TB_LOW);
    assign rd_ah = rd && !run && hit(addr, rco_pkg::ADDR_TA_HIGH);
    assign rd_bh = rd && !run && hit(addr, rco_pkg::ADDR_TB_HIGH);

    // oscillator sample and rising-edge detect
    always_ff @(posedge clk) begin
        if (reset) begin
            rc_q      <= 1'b0;
            rc_prev_q <= 1'b0;
        end else begin
            rc_q      <= rc_osc;
            rc_prev_q <= rc_q;
        end
    end

    assign tick_b = active && rc_q && !rc_prev_q;

    rco_ref_tick #(
        .DIV(rco_pkg::REF_DIV)
    ) u_ref (
        .clk    (clk),
        .reset  (reset),
        .active (active),
        .sel    (sel),
        .tick   (tick_a)
    );

    rco_timer #(
        .WIDTH(WIDTH)
    ) u_timer_a (
        .clk      (clk),
        .reset    (reset),
        .count_en (tick_a),
        .wr_high  (wr_ah),
        .wr_low   (wr_al),
        .rd_high  (rd_ah),
        .wdata    (wdata),
        .cnt_q    (cnt_a),
        .buf_q    (buf_a),
        .wrap     (wrap_a)
    );

    rco_timer #(
        .WIDTH(WIDTH)
    ) u_timer_b (
        .clk      (clk),
        .reset    (reset),
        .count_en (tick_b),
        .wr_high  (wr_bh),
        .wr_low   (wr_bl),
        .rd_high  (rd_bh),
        .wdata    (wdata),
        .cnt_q    (cnt_b),
        .buf_q    (buf_b),
        .wrap     (wrap_b)
    );

    // only the chosen timer ends the measurement
    assign sel_ovf = mode_q[rco_pkg::MODE_OVF_BIT] ? wrap_b : wrap_a;

    // control register; overflow clear beats a software write
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= rco_pkg::CTRL_RESET;
        end else begin
            if (wr && hit(addr, rco_pkg::ADDR_CTRL)) begin
                ctrl_q <= wdata & rco_pkg::CTRL_WMASK;
            end
            if (sel_ovf) begin
                ctrl_q[rco_pkg::CTRL_RUN_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q <= rco_pkg::MODE_RESET;
        end else if (wr && hit(addr, rco_pkg::ADDR_MODE)) begin
            mode_q <= wdata & rco_pkg::MODE_WMASK;
        end
    end

    // sticky request flag, write one to clear, set wins
    assign flag_clr = wr && hit(addr, rco_pkg::ADDR_IRQ_STAT)
                      && wdata[rco_pkg::IRQ_FLAG_BIT];

    always_ff @(posedge clk) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (sel_ovf) begin
            flag_q <= 1'b1;
        end else if (flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mask_q <= 1'b0;
        end else if (wr && hit(addr, rco_pkg::ADDR_IRQ_MASK)) begin
            mask_q <= wdata[rco_pkg::IRQ_FLAG_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_q && mask_q;
        end
    end

    // read mux; timer bytes read as zero while running
    always_comb begin
        rdata_d = rco_pkg::READ_ZERO;
        case (addr)
            rco_pkg::ADDR_CTRL:     rdata_d = ctrl_q;
            rco_pkg::ADDR_MODE:     rdata_d = mode_q;
            rco_pkg::ADDR_IRQ_STAT: begin
                rdata_d[rco_pkg::IRQ_FLAG_BIT] = flag_q;
            end
            rco_pkg::ADDR_IRQ_MASK: begin
                rdata_d[rco_pkg::IRQ_FLAG_BIT] = mask_q;
            end
            rco_pkg::ADDR_TA_HIGH: begin
                if (!run) rdata_d = cnt_a[WIDTH-1:WIDTH-8];
            end
            rco_pkg::ADDR_TA_LOW: begin
                if (!run) rdata_d = buf_a;
            end
            rco_pkg::ADDR_TB_HIGH: begin
                if (!run) rdata_d = cnt_b[WIDTH-1:WIDTH-8];
            end
            rco_pkg::ADDR_TB_LOW: begin
                if (!run) rdata_d = buf_b;
            end
            default: rdata_d = rco_pkg::READ_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= rco_pkg::READ_ZERO;
        end else if (rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= rco_pkg::READ_ZERO;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    stop_on_overflow_a: assert property (sel_ovf |=> !run)
        else $error("run bit not cleared after selected overflow");

    flag_on_overflow_a: assert property (sel_ovf |=> flag_q)
        else $error("request flag not set on selected overflow");

    flag_sticky_a: assert property (flag_q && !flag_clr |=> flag_q)
        else $error("request flag dropped without software clear");

    source_select_a: assert property (
        mode_q[rco_pkg::MODE_OVF_BIT] && wrap_a && !wrap_b |=> run ||
        $past(wr && hit(addr, rco_pkg::ADDR_CTRL)))
        else $error("timer a overflow stopped a timer b measurement");

    idle_hold_a: assert property (
        !active && !wr |=> $stable(cnt_a) && $stable(cnt_b))
        else $error("timer moved while converter idle");

    low_write_a: assert property (wr_al |=> $stable(cnt_a) &&
        buf_a == $past(wdata))
        else $error("low byte write changed count or missed buffer");

    high_write_a: assert property (wr_ah |=>
        cnt_a == {$past(wdata), $past(buf_a)})
        else $error("high byte write did not load both bytes");

    high_latch_a: assert property (rd_ah |=> buf_a == $past(cnt_a[7:0])
        && rdata_q == $past(cnt_a[WIDTH-1:WIDTH-8]))
        else $error("high byte read did not latch low byte");

    run_block_a: assert property (
        rd && run && (hit(addr, rco_pkg::ADDR_TA_HIGH)
        || hit(addr, rco_pkg::ADDR_TA_LOW)
        || hit(addr, rco_pkg::ADDR_TB_HIGH)
        || hit(addr, rco_pkg::ADDR_TB_LOW))
        |=> rdata_q == rco_pkg::READ_ZERO
        ##0 $stable(buf_a) && $stable(buf_b))
        else $error("timer register reachable while running");

    ctrl_zero_a: assert property (
        rd && hit(addr, rco_pkg::ADDR_CTRL) |=> rdata_q[2:0] == 3'h0)
        else $error("control reserved bits not zero");

    mode_zero_a: assert property (
        rd && hit(addr, rco_pkg::ADDR_MODE) |=> rdata_q[3:2] == 2'h0)
        else $error("mode reserved bits not zero");

    unused_sel_a: assert property (
        sel > rco_pkg::SEL_SYS_DIV4 && !wr_ah |=> $stable(cnt_a))
        else $error("timer a counted with unused select");

    div4_rate_a: assert property (
        active && sel == rco_pkg::SEL_SYS_DIV4 && tick_a |=> !tick_a [*3])
        else $error("divided reference ticked too often");

    irq_level_a: assert property (flag_q && mask_q |=> irq_q)
        else $error("interrupt output not raised");

    irq_drop_a: assert property (!(flag_q && mask_q) |=> !irq_q)
        else $error("interrupt output high without unmasked flag");

    flag_clear_a: assert property (flag_clr && !sel_ovf |=> !flag_q)
        else $error("write one did not clear request flag");

    read_idle_a: assert property (!rd |=> rdata_q == rco_pkg::READ_ZERO)
        else $error("read data not zero outside read answer");

    run_start_a: assert property (
        wr && hit(addr, rco_pkg::ADDR_CTRL) && wdata[rco_pkg::CTRL_RUN_BIT]
        && !sel_ovf |=> run)
        else $error("run bit write did not start the converter");

    ctrl_store_a: assert property (
        wr && hit(addr, rco_pkg::ADDR_CTRL) && !sel_ovf |=>
        ctrl_q == ($past(wdata) & rco_pkg::CTRL_WMASK))
        else $error("control write not stored as masked");

    mode_store_a: assert property (
        wr && hit(addr, rco_pkg::ADDR_MODE) |=>
        mode_q == ($past(wdata) & rco_pkg::MODE_WMASK))
        else $error("mode write not stored as masked");

    sys_count_a: assert property (
        active && sel == rco_pkg::SEL_SYS |=>
        cnt_a == $past(cnt_a) + WIDTH'(1))
        else $error("timer a missed a system clock tick");

    b_edge_count_a: assert property (
        active && rc_q && !rc_prev_q |=>
        cnt_b == $past(cnt_b) + WIDTH'(1))
        else $error("timer b missed an oscillator edge");

    b_hold_a: assert property (
        !(rc_q && !rc_prev_q) && !wr_bh |=> $stable(cnt_b))
        else $error("timer b moved without an oscillator edge");

    a_low_read_a: assert property (
        rd && !run && hit(addr, rco_pkg::ADDR_TA_LOW) |=>
        rdata_q == $past(buf_a))
        else $error("timer a low read did not return buffer");

    b_low_read_a: assert property (
        rd && !run && hit(addr, rco_pkg::ADDR_TB_LOW) |=>
        rdata_q == $past(buf_b))
        else $error("timer b low read did not return buffer");

    b_high_write_a: assert property (
        wr_bh |=>
        cnt_b == {$past(wdata), $past(buf_b)})
        else $error("timer b high write did not load both bytes");

    b_high_latch_a: assert property (
        rd_bh |=> buf_b == $past(cnt_b[7:0])
        && rdata_q == $past(cnt_b[WIDTH-1:WIDTH-8]))
        else $error("timer b high read did not latch low byte");

    overflow_a_c: cover property (
        !mode_q[rco_pkg::MODE_OVF_BIT] && sel_ovf);
    overflow_b_c: cover property (
        mode_q[rco_pkg::MODE_OVF_BIT] && sel_ovf);
    read_pair_c: cover property (
        rd_ah ##1 rd && hit(addr, rco_pkg::ADDR_TA_LOW));
    blocked_read_c: cover property (
        rd && run && hit(addr, rco_pkg::ADDR_TA_HIGH));
    div4_tick_c: cover property (
        active && sel == rco_pkg::SEL_SYS_DIV4 && tick_a);
endmodule

/* File: rtl/rco_pkg.sv */
// constants shared by the oscillation converter design
package rco_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1E;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1F;
    localparam logic [7:0] ADDR_TA_HIGH  = 8'h20;
    localparam logic [7:0] ADDR_TA_LOW   = 8'h21;
    localparam logic [7:0] ADDR_CTRL     = 8'h22;
    localparam logic [7:0] ADDR_TB_HIGH  = 8'h23;
    localparam logic [7:0] ADDR_TB_LOW   = 8'h24;
    localparam logic [7:0] ADDR_MODE     = 8'h25;

    // converter_control fields
    localparam int         CTRL_RUN_BIT  = 4;
    localparam int         CTRL_SEL_LSB  = 5;
    localparam int         CTRL_SEL_MSB  = 7;
    localparam logic [7:0] CTRL_WMASK    = 8'hF8;
    localparam logic [7:0] CTRL_RESET    = 8'h08;

    // converter_mode fields
    localparam int         MODE_OVF_BIT  = 0;
    localparam int         MODE_EN_BIT   = 1;
    localparam logic [7:0] MODE_WMASK    = 8'hF3;
    localparam logic [7:0] MODE_RESET    = 8'h00;

    // interrupt status and mask
    localparam int         IRQ_FLAG_BIT  = 4;
    localparam logic [7:0] IRQ_WMASK     = 8'h10;

    // reference clock select codes
    localparam logic [2:0] SEL_SYS       = 3'h0;
    localparam logic [2:0] SEL_SYS_DIV4  = 3'h1;
    localparam int         REF_DIV       = 4;

    localparam int         TIMER_WIDTH   = 16;
    localparam logic [7:0] READ_ZERO     = 8'h00;
endpackage

/* File: rtl/rco_ref_tick.sv */
// reference tick for timer a: system clock or system clock over four
`timescale 1ns/100ps
module rco_ref_tick #(
    parameter int DIV = rco_pkg::REF_DIV
) (
    input  wire logic       clk,    // system clock
    input  wire logic       reset,  // synchronous reset, active high
    input  wire logic       active, // converter counting
    input  wire logic [2:0] sel,    // reference select code
    output logic            tick    // one-cycle count enable
);
    localparam int PW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [PW-1:0] LAST = PW'(DIV - 1);

    logic [PW-1:0] div_q;

    always_ff @(posedge clk) begin
        if (reset || !active) begin
            div_q <= '0;
        end else begin
            div_q <= (div_q == LAST) ? '0 : div_q + PW'(1);
        end
    end

    always_comb begin
        case (sel)
            rco_pkg::SEL_SYS:      tick = active;
            rco_pkg::SEL_SYS_DIV4: tick = active && (div_q == LAST);
            default:               tick = 1'b0;
        endcase
    end
endmodule

/* File: rtl/rco_timer.sv */
// 16-bit count-up timer with low-byte buffer
`timescale 1ns/100ps
module rco_timer #(
    parameter int WIDTH = rco_pkg::TIMER_WIDTH
) (
    input  wire logic             clk,      // system clock
    input  wire logic             reset,    // synchronous reset
    input  wire logic             count_en, // increment this cycle
    input  wire logic             wr_high,  // high-byte write
    input  wire logic             wr_low,   // low-byte write
    input  wire logic             rd_high,  // high-byte read
    input  wire logic [7:0]       wdata,    // write data
    output logic      [WIDTH-1:0] cnt_q,    // count value
    output logic      [7:0]       buf_q,    // low-byte buffer
    output logic                  wrap      // overflow this cycle
);
    assign wrap = count_en && (&cnt_q);

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (wr_high) begin
            cnt_q <= WIDTH'({wdata, buf_q});
        end else if (count_en) begin
            cnt_q <= cnt_q + WIDTH'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            buf_q <= '0;
        end else if (wr_low) begin
            buf_q <= wdata;
        end else if (rd_high) begin
            buf_q <= cnt_q[7:0];
        end
    end
endmodule

/* File: tb/rco_osc_model.sv */
// behavioural resistor-capacitor oscillator driving timer b
`timescale 1ns/100ps
module rco_osc_model (
    input  wire logic       clk,  // system clock
    input  wire logic       run,  // oscillator powered
    input  wire logic [3:0] half, // half period in clk cycles
    output logic            osc   // oscillator output
);
    logic [3:0] cnt_q;

    // idles low when stopped; each phase lasts at least one clk
    always_ff @(posedge clk) begin
        if (!run) begin
            cnt_q <= 4'h0;
            osc   <= 1'b0;
        end else if (cnt_q + 4'h1 >= half) begin
            cnt_q <= 4'h0;
            osc   <= ~osc;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

/* File: tb/rco_conv_bench.sv */
// self-checking bench for the oscillation converter
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    fail_count++; \
    $display("FAIL t=%0t got %h exp %h", $time, got, exp); end end
module rco_conv_bench;
    logic       clk;
    logic       reset;
    logic       osc_run;
    logic       rc_osc;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata_q;
    logic       irq_q;
    int         fail_count;
    int         checked;
    int         n;
    logic [7:0] m_tab [2];
    logic [7:0] c_tab [2];

    initial clk = 1'b0;
    always #5 clk = ~clk;

    rco_conv dut (.clk(clk), .reset(reset), .rc_osc(rc_osc), .addr(addr),
                  .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
                  .irq_q(irq_q));
    rco_osc_model osc (.clk(clk), .run(osc_run), .half(4'h3), .osc(rc_osc));

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata_q, exp)
    endtask

    // low byte sits one offset above its high byte
    task automatic ld16(input logic [7:0] a, input logic [15:0] v);
        wr_reg(a + 8'h01, v[7:0]);
        wr_reg(a, v[15:8]);
    endtask

    task automatic chk16(input logic [7:0] a, input logic [15:0] v);
        rd_reg(a, v[15:8]);
        rd_reg(a + 8'h01, v[7:0]);
    endtask

    task automatic wait_irq(input int lim);
        n = 0;
        while (irq_q !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic final_report;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        final_report;
    end

    initial begin
        reset      = 1'b1;
        osc_run    = 1'b0;
        addr       = 8'h00;
        wdata      = 8'h00;
        wr         = 1'b0;
        rd         = 1'b0;
        fail_count = 0;
        checked    = 0;
        m_tab      = '{8'h02, 8'h00};
        c_tab      = '{8'h50, 8'h10};
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd_reg(rco_pkg::ADDR_CTRL, 8'h08);
        rd_reg(rco_pkg::ADDR_MODE, 8'h00);
        rd_reg(rco_pkg::ADDR_IRQ_STAT, 8'h00);
        wr_reg(rco_pkg::ADDR_CTRL, 8'hEF);
        rd_reg(rco_pkg::ADDR_CTRL, 8'hE8);
        wr_reg(rco_pkg::ADDR_MODE, 8'hFC);
        rd_reg(rco_pkg::ADDR_MODE, 8'hF0);
        wr_reg(rco_pkg::ADDR_MODE, 8'h0F);
        rd_reg(rco_pkg::ADDR_MODE, 8'h03);
        wr_reg(rco_pkg::ADDR_IRQ_MASK, 8'hFF);
        rd_reg(rco_pkg::ADDR_IRQ_MASK, 8'h10);
        wr_reg(8'h30, 8'h5A);
        rd_reg(8'h30, 8'h00);
        wr_reg(rco_pkg::ADDR_CTRL, 8'h00);
        // low byte buffer against live count
        wr_reg(rco_pkg::ADDR_TA_LOW, 8'h34);
        rd_reg(rco_pkg::ADDR_TA_LOW, 8'h34);
        rd_reg(rco_pkg::ADDR_TA_HIGH, 8'h00);
        rd_reg(rco_pkg::ADDR_TA_LOW, 8'h00);
        ld16(rco_pkg::ADDR_TA_HIGH, 16'hFFFE);
        chk16(rco_pkg::ADDR_TA_HIGH, 16'hFFFE);
        // unused select code, then converter disabled: nothing counts
        for (int i = 0; i < 2; i++) begin
            wr_reg(rco_pkg::ADDR_MODE, m_tab[i]);
            wr_reg(rco_pkg::ADDR_CTRL, c_tab[i]);
            repeat (20) @(posedge clk);
            rd_reg(rco_pkg::ADDR_CTRL, c_tab[i]);
            rd_reg(rco_pkg::ADDR_IRQ_STAT, 8'h00);
            wr_reg(rco_pkg::ADDR_CTRL, 8'h00);
            chk16(rco_pkg::ADDR_TA_HIGH, 16'hFFFE);
        end
        // timer a on system clock overflows after two ticks
        wr_reg(rco_pkg::ADDR_MODE, 8'h02);
        wr_reg(rco_pkg::ADDR_CTRL, 8'h10);
        wait_irq(10);
        `CHK(n < 6, 1'b1)
        rd_reg(rco_pkg::ADDR_CTRL, 8'h00);
        rd_reg(rco_pkg::ADDR_IRQ_STAT, 8'h10);
        repeat (10) @(posedge clk);
        rd_reg(rco_pkg::ADDR_IRQ_STAT, 8'h10);
        chk16(rco_pkg::ADDR_TA_HIGH, 16'h0000);
        wr_reg(rco_pkg::ADDR_IRQ_STAT, 8'h10);
        @(posedge clk);
        #1;
        `CHK(irq_q, 1'b0)
        // divide by four, masked, registers blocked while running
        wr_reg(rco_pkg::ADDR_IRQ_MASK, 8'h00);
        ld16(rco_pkg::ADDR_TA_HIGH, 16'hFFF0);
        wr_reg(rco_pkg::ADDR_CTRL, 8'h30);
        repeat (30) @(posedge clk);
        rd_reg(rco_pkg::ADDR_TA_HIGH, 8'h00);
        ld16(rco_pkg::ADDR_TA_HIGH, 16'h1122);
        rd_reg(rco_pkg::ADDR_IRQ_STAT, 8'h00);
        repeat (60) @(posedge clk);
        rd_reg(rco_pkg::ADDR_IRQ_STAT, 8'h10);
        `CHK(irq_q, 1'b0)
        wr_reg(rco_pkg::ADDR_IRQ_MASK, 8'h10);
        @(posedge clk);
        #1;
        `CHK(irq_q, 1'b1)
        chk16(rco_pkg::ADDR_TA_HIGH, 16'h0000);
        wr_reg(rco_pkg::ADDR_IRQ_STAT, 8'h10);
        // timer b overflow on oscillator edges ends the run
        // timer a wraps mid-run without ending a timer b measurement
        ld16(rco_pkg::ADDR_TA_HIGH, 16'hFFFA);
        ld16(rco_pkg::ADDR_TB_HIGH, 16'hFFFE);
        wr_reg(rco_pkg::ADDR_MODE, 8'h03);
        osc_run <= 1'b1;
        wr_reg(rco_pkg::ADDR_CTRL, 8'h10);
        wait_irq(80);
        `CHK(irq_q, 1'b1)
        repeat (20) @(posedge clk);
        chk16(rco_pkg::ADDR_TB_HIGH, 16'h0000);
        chk16(rco_pkg::ADDR_TA_HIGH, 16'h0003);
        rd_reg(rco_pkg::ADDR_CTRL, 8'h00);
        osc_run <= 1'b0;
        final_report;
    end
endmodule
